/* logic/bpw_pkg.sv */
package bpw_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_PMCSR = 8'h00;
    localparam logic [7:0] OFF_PMCAP = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_PRELOAD = 8'h14;
    localparam logic [7:0] OFF_DBYTES_LO = 8'h18;
    localparam logic [7:0] OFF_DBYTES_HI = 8'h1C;
    localparam logic [7:0] OFF_LOCK = 8'h20;
    // Control/status field positions
    localparam int PS_LSB = 0;
    localparam int WAKE_EN_BIT = 8;
    localparam int DSEL_LSB = 9;
    localparam int DSCALE_LSB = 13;
    localparam int WAKE_ST_BIT = 15;
    // Preload word field positions
    localparam int PL_REV_LSB = 0;
    localparam int PL_D1_BIT = 3;
    localparam int PL_D2_BIT = 4;
    localparam int PL_WAKE_LSB = 5;
    localparam int PL_DEN_BIT = 9;
    localparam int PL_DSI_BIT = 10;
    localparam int PL_SCALE_LSB = 11;
    // Interrupt status bits
    localparam int IRQ_D0_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    // Power states
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;
    // Reset values
    localparam logic [31:0] PRELOAD_RST = 32'h00000000;
    localparam logic [1:0] IRQ_MASK_RST = 2'h3;
    // Timing
    localparam int CLK_HZ = 20000000;
    localparam int SEC_RST_US = 100;
    localparam int SEC_RST_CYC = (SEC_RST_US * (CLK_HZ / 1000000));
    localparam int PRELOAD_CYC = 16;

    typedef enum logic [1:0] {
        BPW_RUN,
        BPW_CHIP_RST,
        BPW_PRELOAD
    } bpw_seq_e;

    typedef struct packed {
        logic [2:0] rev;
        logic d1_ok;
        logic d2_ok;
        logic [3:0] wake_ok;
        logic data_en;
        logic dsi;
        logic [1:0] scale;
    } bpw_cap_s;
endpackage : bpw_pkg

/* logic/bpw_power_wake.sv */
// Functional notes
// RQ1 - Power state changes on control field write
// RQ2 - Software only goes up to D0
// RQ3 - Downward transitions take no hardware action
// RQ4 - D1/D2 to D0 sets flag, interrupt
// RQ5 - D3hot to D0 resets, holds secondary reset
// RQ6 - D3cold needs nothing beyond power-up reset
// RQ7 - Local processor clears lockout early
// RQ8 - Wake out low on input, support, enable
// RQ9 - Wake status set regardless of enable
// RQ10 - Wake out released when status/enable cleared
// RQ11 - Subsystem releases wake before status clear
// RQ12 - Preload sets capability fields
// RQ13 - Eight data bytes, selected by select field
// RQ14 - Data reads zero unless reporting enabled
// RQ15 - Lockout retries config except reset control
// RQ16 - Two-bit state, unsupported writes ignored
// RQ17 - Wake input synchronized by two flops
`timescale 1ns/10ps
`default_nettype none
module bpw_power_wake
    import bpw_pkg::*;
#(
    parameter int SEC_RST_CYCLES = SEC_RST_CYC,
    parameter int PRELOAD_CYCLES = PRELOAD_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [31:0] preload_word,
    input wire logic [63:0] preload_bytes,
    input wire logic lockout_strap,
    input wire logic cfg_access,
    input wire logic cfg_is_rst_ctl,
    output logic cfg_retry,
    input wire logic sec_wake_n,
    output logic pri_wake_n,
    output logic sec_rst_n,
    output logic sec_irq,
    output logic preload_busy,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Counters need at least one cycle per phase
    if (SEC_RST_CYCLES < 1 || PRELOAD_CYCLES < 1) begin : g_bad_count
        $error("bpw_power_wake: counts must be positive");
    end

    localparam int CW = $clog2(SEC_RST_CYCLES + PRELOAD_CYCLES + 2);

    // Two-flop reset release
    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end
    wire logic rst_n = rst_n_reg;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // State
    bpw_seq_e seq_reg;
    logic [CW-1:0] cnt_reg;
    logic [1:0] ps_reg;
    logic wake_en_reg, wake_st_reg;
    logic [3:0] dsel_reg;
    bpw_cap_s cap_reg;
    logic [63:0] dbytes_reg;
    logic [1:0] irq_st_reg, irq_mask_reg;
    logic lock_reg, strap_pend_reg;
    logic wsync1_reg, wsync2_reg;

    // AXI write side holding registers
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
    wire logic aw_hs = s_axi_awvalid & s_axi_awready;
    wire logic w_hs = s_axi_wvalid & s_axi_wready;
    wire logic [7:0] wa = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
    wire logic [31:0] wd = w_got_reg ? w_data_reg : s_axi_wdata;
    wire logic [3:0] wb = w_got_reg ? w_strb_reg : s_axi_wstrb;
    wire logic wr_go = (aw_got_reg | aw_hs) & (w_got_reg | w_hs);
    wire logic run = (seq_reg == BPW_RUN);
    wire logic wr_ok = wr_go & run;

    // Decoded writes
    wire logic wr_csr = wr_ok & (wa == OFF_PMCSR);
    wire logic wr_stat = wr_ok & (wa == OFF_IRQ_STAT) & wb[0];
    wire logic wr_mask = wr_ok & (wa == OFF_IRQ_MASK) & wb[0];
    wire logic wr_lock = wr_ok & (wa == OFF_LOCK) & wb[0];
    wire logic [31:0] csr_cur = {16'h0000, wake_st_reg, cap_reg.scale,
        dsel_reg, wake_en_reg, 6'h00, ps_reg};
    wire logic [31:0] csr_w = merge(csr_cur, wd, wb);
    wire logic [1:0] ps_req = csr_w[PS_LSB +: 2];

    // Supported target check and transition classes
    wire logic ps_supported = (ps_req == PS_D0) | (ps_req == PS_D3)
        | ((ps_req == PS_D1) & cap_reg.d1_ok)
        | ((ps_req == PS_D2) & cap_reg.d2_ok);
    wire logic ps_upward = (ps_req != PS_D0) & (ps_req < ps_reg);
    wire logic ps_take = wr_csr & ps_supported & ~ps_upward; // RQ16
    wire logic to_d0_soft = ps_take & (ps_req == PS_D0)
        & ((ps_reg == PS_D1) | (ps_reg == PS_D2)); // RQ4
    wire logic to_d0_hard = ps_take & (ps_req == PS_D0)
        & (ps_reg == PS_D3); // RQ5

    // Wake qualification on synchronized input
    wire logic wake_sup = cap_reg.wake_ok[ps_reg];
    wire logic wake_evt = ~wsync2_reg & wake_sup; // RQ9 RQ17
    wire logic st_clr = wr_csr & wb[1] & wd[WAKE_ST_BIT];
    wire logic [1:0] irq_evt = {wake_evt, to_d0_soft};
    wire logic [1:0] irq_clr = wr_stat ? wd[1:0] : 2'h0;
    // Set beats clear on every sticky bit
    wire logic [1:0] irq_st_next = (irq_st_reg & ~irq_clr) | irq_evt;
    wire logic wake_st_next = (wake_st_reg & ~st_clr) | wake_evt;
    wire logic wake_en_next = wr_csr ? csr_w[WAKE_EN_BIT] : wake_en_reg;
    // Wake out follows enable and status together
    wire logic pri_wake_hold = ~pri_wake_n & wake_st_next & wake_en_next;
    wire logic pri_wake_next = ~(wake_st_next & wake_en_next
        & ~wsync2_reg & wake_sup | pri_wake_hold); // RQ8 RQ10

    // Read mux
    wire logic [7:0] sel_byte = dbytes_reg[dsel_reg[2:0]*8 +: 8];
    wire logic [7:0] data_rd = (cap_reg.data_en & ~dsel_reg[3])
        ? sel_byte : 8'h00; // RQ13 RQ14
    wire logic [31:0] cap_rd = {21'h000000, cap_reg.dsi, cap_reg.data_en,
        cap_reg.wake_ok, cap_reg.d2_ok, cap_reg.d1_ok, cap_reg.rev};
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h00000000;
        case (s_axi_araddr)
            OFF_PMCSR: rd_val = csr_cur;
            OFF_PMCAP: rd_val = cap_rd;
            OFF_DATA: rd_val = {24'h000000, data_rd};
            OFF_IRQ_STAT: rd_val = {30'h00000000, irq_st_reg};
            OFF_IRQ_MASK: rd_val = {30'h00000000, irq_mask_reg};
            OFF_LOCK: rd_val = {31'h00000000, lock_reg};
            default: rd_val = 32'h00000000;
        endcase
    end
    wire logic rd_known = (s_axi_araddr <= OFF_LOCK)
        & (s_axi_araddr[1:0] == 2'h0)
        & (s_axi_araddr != OFF_PRELOAD)
        & (s_axi_araddr != OFF_DBYTES_LO)
        & (s_axi_araddr != OFF_DBYTES_HI);
    wire logic wr_known = (wa == OFF_PMCSR) | (wa == OFF_IRQ_STAT)
        | (wa == OFF_IRQ_MASK) | (wa == OFF_LOCK);
    assign s_axi_arready = ~s_axi_rvalid;
    wire logic ar_hs = s_axi_arvalid & s_axi_arready;

    // AXI handshakes and responses
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
        end else if (clk_en) begin
            if (wr_go) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_known & run) ? 2'h0 : 2'h2;
            end else begin
                if (aw_hs) aw_got_reg <= 1'b1;
                if (w_hs) w_got_reg <= 1'b1;
                if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
            end
            if (aw_hs) aw_addr_reg <= s_axi_awaddr;
            if (w_hs) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Reset and preload sequencer
    wire logic [CW-1:0] rst_last = CW'(SEC_RST_CYCLES - 1);
    wire logic [CW-1:0] pl_last = CW'(PRELOAD_CYCLES - 1);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_reg <= BPW_PRELOAD; // RQ6
            cnt_reg <= '0;
            sec_rst_n <= 1'b0;
            preload_busy <= 1'b1;
        end else if (clk_en) begin
            case (seq_reg)
                BPW_RUN: begin
                    // Downward moves leave this state alone
                    if (to_d0_hard) begin // RQ3 RQ5
                        seq_reg <= BPW_CHIP_RST;
                        cnt_reg <= '0;
                        sec_rst_n <= 1'b0;
                        preload_busy <= 1'b1;
                    end
                end
                BPW_CHIP_RST: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == rst_last) begin // RQ5
                        seq_reg <= BPW_PRELOAD;
                        cnt_reg <= '0;
                        sec_rst_n <= 1'b1;
                    end
                end
                BPW_PRELOAD: begin
                    sec_rst_n <= 1'b1;
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == pl_last) begin
                        seq_reg <= BPW_RUN;
                        cnt_reg <= '0;
                        preload_busy <= 1'b0;
                    end
                end
                default: seq_reg <= BPW_RUN;
            endcase
        end
    end

    // Power management state, soft-reset by the chip reset phase
    wire logic chip_rst = (seq_reg == BPW_CHIP_RST);
    wire logic pl_done = (seq_reg == BPW_PRELOAD) & (cnt_reg == pl_last);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_reg <= PS_D0;
            wake_en_reg <= 1'b0;
            wake_st_reg <= 1'b0;
            dsel_reg <= 4'h0;
            cap_reg <= '0;
            dbytes_reg <= 64'h0000000000000000;
            irq_st_reg <= 2'h0;
            irq_mask_reg <= IRQ_MASK_RST;
            lock_reg <= 1'b1;
            strap_pend_reg <= 1'b1;
            wsync1_reg <= 1'b1;
            wsync2_reg <= 1'b1;
            pri_wake_n <= 1'b1;
            sec_irq <= 1'b0;
            cfg_retry <= 1'b0;
        end else if (clk_en) begin
            wsync1_reg <= sec_wake_n; // RQ17
            wsync2_reg <= wsync1_reg; // RQ17
            if (chip_rst) begin
                ps_reg <= PS_D0;
                wake_en_reg <= 1'b0;
                wake_st_reg <= 1'b0;
                dsel_reg <= 4'h0;
                irq_st_reg <= 2'h0;
                irq_mask_reg <= IRQ_MASK_RST; // RQ5
                strap_pend_reg <= 1'b1;
                pri_wake_n <= 1'b1;
                sec_irq <= 1'b0;
            end else begin
                if (ps_take) ps_reg <= ps_req; // RQ1
                if (wr_csr) dsel_reg <= csr_w[DSEL_LSB +: 4];
                wake_en_reg <= wake_en_next;
                wake_st_reg <= wake_st_next; // RQ9
                irq_st_reg <= irq_st_next; // RQ4
                if (wr_mask) irq_mask_reg <= wd[1:0];
                pri_wake_n <= pri_wake_next; // RQ8
                sec_irq <= |(irq_st_next & ~irq_mask_reg); // RQ4
            end
            if (pl_done) begin // RQ12 RQ13
                cap_reg.rev <= preload_word[PL_REV_LSB +: 3];
                cap_reg.d1_ok <= preload_word[PL_D1_BIT];
                cap_reg.d2_ok <= preload_word[PL_D2_BIT];
                cap_reg.wake_ok <= preload_word[PL_WAKE_LSB +: 4];
                cap_reg.data_en <= preload_word[PL_DEN_BIT];
                cap_reg.dsi <= preload_word[PL_DSI_BIT];
                cap_reg.scale <= preload_word[PL_SCALE_LSB +: 2];
                dbytes_reg <= preload_bytes;
            end
            // Strap caught once after each reset, then software owns it
            if (strap_pend_reg && !chip_rst) begin
                lock_reg <= lockout_strap;
                strap_pend_reg <= 1'b0;
            end else if (wr_lock) begin
                lock_reg <= wd[0]; // RQ7
            end
            cfg_retry <= cfg_access & ~cfg_is_rst_ctl
                & (lock_reg | ~run); // RQ15
        end
    end

    // Guards
    a_wake_needs_cause: assert property (@(posedge core_clk) // RQ8
        disable iff (!rst_n)
        (clk_en && $fell(pri_wake_n)) |-> ($past(wake_en_next)
        && $past(wake_sup) && !$past(wsync2_reg)))
        else $error("wake out asserted without cause");
    a_wake_release: assert property (@(posedge core_clk) // RQ10
        disable iff (!rst_n)
        (clk_en && !chip_rst && !wake_en_next && run)
        |=> pri_wake_n)
        else $error("wake out not released");
    a_wake_status_set: assert property (@(posedge core_clk) // RQ9
        disable iff (!rst_n)
        (clk_en && wake_evt && !chip_rst) |=> wake_st_reg)
        else $error("wake status not set");
    a_sync_delay: assert property (@(posedge core_clk) // RQ17
        disable iff (!rst_n)
        (clk_en && $past(clk_en)) |-> (wsync2_reg == $past(wsync1_reg)))
        else $error("wake synchronizer skipped");
    a_soft_d0_irq: assert property (@(posedge core_clk) // RQ4
        disable iff (!rst_n)
        (clk_en && to_d0_soft && !irq_mask_reg[IRQ_D0_BIT])
        |=> (sec_irq && irq_st_reg[IRQ_D0_BIT]))
        else $error("return to D0 not flagged");
    sequence s_hard_d0;
        clk_en && to_d0_hard;
    endsequence
    a_hard_d0_reset: assert property (@(posedge core_clk) // RQ5
        disable iff (!rst_n)
        s_hard_d0 |=> (!sec_rst_n && chip_rst)[*8])
        else $error("secondary reset not held");
    a_no_up_nonzero: assert property (@(posedge core_clk) // RQ2
        disable iff (!rst_n)
        (clk_en && wr_csr && ps_upward && !chip_rst)
        |=> $stable(ps_reg))
        else $error("illegal state change accepted");
    a_data_zero: assert property (@(posedge core_clk) // RQ14
        disable iff (!rst_n)
        (!cap_reg.data_en) |-> (data_rd == 8'h00))
        else $error("data read not zero");
    a_down_no_action: assert property (@(posedge core_clk) // RQ3
        disable iff (!rst_n)
        (clk_en && run && ps_take && ps_req != PS_D0)
        |=> (run && sec_rst_n))
        else $error("action on downward move");
    a_lock_retry: assert property (@(posedge core_clk) // RQ15
        disable iff (!rst_n)
        (clk_en && cfg_access && !cfg_is_rst_ctl && lock_reg)
        |=> cfg_retry)
        else $error("locked access not retried");
endmodule // bpw_power_wake
`default_nettype wire

/* testbench/bpw_subsys_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Subsystem behind the bridge: asks for wake on its active-low line
module bpw_subsys_model (
    input wire logic sec_rst_n,
    input wire logic wake_req,
    output logic sec_wake_n
);
    // Held in reset the subsystem cannot request; idle level is high
    assign sec_wake_n = ~(wake_req & sec_rst_n);
endmodule // bpw_subsys_model
`default_nettype wire

/* testbench/bridge_power_state_and_wake_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module bridge_power_state_and_wake_control_tb;
    import bpw_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } bpw_row_s;
    localparam logic [31:0] PLW = 32'h000017AA;
    localparam logic [63:0] PLB = 64'hF0E1D2C3B4A59687;
    localparam int SRC = 20;
    localparam int PLC = 4;
    localparam logic [31:0] CS = 32'h00004000;
    logic core_clk, reset_n, wake_req, sec_wake_n, lockout_strap;
    logic cfg_access, cfg_is_rst_ctl, cfg_retry, pri_wake_n, sec_rst_n;
    logic sec_irq, preload_busy;
    logic [31:0] preload_word, s_axi_wdata, s_axi_rdata, rdat;
    logic [63:0] preload_bytes;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int n_fail, compares, n, s, low_cnt, pl_cnt;
    bpw_row_s rows[$];

    bpw_power_wake #(.SEC_RST_CYCLES(SRC), .PRELOAD_CYCLES(PLC)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
        .preload_word(preload_word), .preload_bytes(preload_bytes),
        .lockout_strap(lockout_strap), .cfg_access(cfg_access),
        .cfg_is_rst_ctl(cfg_is_rst_ctl), .cfg_retry(cfg_retry),
        .sec_wake_n(sec_wake_n), .pri_wake_n(pri_wake_n),
        .sec_rst_n(sec_rst_n), .sec_irq(sec_irq),
        .preload_busy(preload_busy), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    bpw_subsys_model i_sub (
        .sec_rst_n(sec_rst_n), .wake_req(wake_req), .sec_wake_n(sec_wake_n)
    );

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Counts secondary reset width and preload length, seen at negedges
    always @(negedge core_clk) begin
        if (reset_n === 1'b1 && sec_rst_n === 1'b0) low_cnt++;
        if (reset_n === 1'b1 && sec_rst_n === 1'b1 && preload_busy === 1'b1)
            pl_cnt++;
    end

    task automatic finish_test;
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // Ready is sampled at the negedge: outputs only move on rising edges
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic ta, tw, done;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(negedge core_clk);
            ta = (s_axi_awvalid & s_axi_awready) === 1'b1;
            tw = (s_axi_wvalid & s_axi_wready) === 1'b1;
            done = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic ta, done;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(negedge core_clk);
            ta = (s_axi_arvalid & s_axi_arready) === 1'b1;
            done = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk({30'h0, r}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk({30'h0, r}, 32'h0);
        chk(d, e);
    endtask

    // Config access: retry answer lands one cycle after the request
    task automatic cfg(input logic rc, input logic e);
        @(posedge core_clk);
        cfg_access <= 1'b1;
        cfg_is_rst_ctl <= rc;
        @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, cfg_retry}, {31'h0, e});
        @(posedge core_clk);
        cfg_access <= 1'b0;
    endtask

    task automatic wait_idle;
        for (n = 0; n < 200 && preload_busy !== 1'b0; n++)
            @(negedge core_clk);
    endtask

    // Hang guard, far above the expected run length
    initial begin
        #(50 * 20000);
        n_fail++;
        finish_test();
    end

    // Main sequence
    initial begin
        n_fail = 0;
        compares = 0;
        reset_n = 1'b0;
        {wake_req, cfg_access, cfg_is_rst_ctl} = 3'h0;
        lockout_strap = 1'b1;
        preload_word = PLW;
        preload_bytes = PLB;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk({sec_rst_n, pri_wake_n, preload_busy}, 32'h3);
        @(posedge core_clk);
        reset_n <= 1'b1;
        wait_idle();
        chk({sec_rst_n, pri_wake_n, sec_irq, preload_busy}, 32'hC);
        // Ordinary accesses: resets, unmapped places, data byte select
        rows.push_back(bpw_row_s'{1'b0, OFF_IRQ_MASK, 32'h0, 32'h3, 2'h0});
        rows.push_back(bpw_row_s'{1'b0, OFF_IRQ_STAT, 32'h0, 32'h0, 2'h0});
        rows.push_back(bpw_row_s'{1'b0, OFF_PMCSR, 32'h0, CS, 2'h0});
        rows.push_back(bpw_row_s'{1'b0, OFF_PMCAP, 32'h0, PLW & 32'h7FF,
                                  2'h0});
        rows.push_back(bpw_row_s'{1'b1, OFF_PRELOAD, 32'h1, 32'h0, 2'h2});
        rows.push_back(bpw_row_s'{1'b0, OFF_DBYTES_LO, 32'h0, 32'h0, 2'h2});
        rows.push_back(bpw_row_s'{1'b1, OFF_DBYTES_HI, 32'h1, 32'h0, 2'h2});
        for (s = 0; s < 8; s++) begin
            rows.push_back(bpw_row_s'{1'b1, OFF_PMCSR, 32'(s) << 9, 32'h0,
                                      2'h0});
            rows.push_back(bpw_row_s'{1'b0, OFF_DATA, 32'h0,
                                      {24'h0, PLB[8 * s +: 8]}, 2'h0});
        end
        foreach (rows[i]) begin
            if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, resp);
            else axi_rd(rows[i].a, rdat, resp);
            chk({30'h0, resp}, {30'h0, rows[i].r});
            if (!rows[i].wr && rows[i].r == 2'h0) chk(rdat, rows[i].e);
        end
        // Lockout retries everything but the reset control access
        cfg(1'b0, 1'b1);
        cfg(1'b1, 1'b0);
        wr(OFF_LOCK, 32'h0);
        cfg(1'b0, 1'b0);
        // State moves, refused state, return-to-D0 interrupt
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_PMCSR, 32'h1);
        rd(OFF_PMCSR, CS | 32'h1);
        rd(OFF_IRQ_STAT, 32'h0);
        @(negedge core_clk);
        chk({31'h0, sec_irq}, 32'h0);
        wr(OFF_PMCSR, 32'h2);
        rd(OFF_PMCSR, CS | 32'h1);
        wr(OFF_PMCSR, 32'h0);
        rd(OFF_IRQ_STAT, 32'h1);
        @(negedge core_clk);
        chk({31'h0, sec_irq}, 32'h1);
        wr(OFF_IRQ_MASK, 32'h1);
        @(negedge core_clk);
        chk({31'h0, sec_irq}, 32'h0);
        wr(OFF_IRQ_MASK, 32'h0);
        @(negedge core_clk);
        chk({31'h0, sec_irq}, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        rd(OFF_IRQ_STAT, 32'h0);
        @(negedge core_clk);
        chk({31'h0, sec_irq}, 32'h0);
        // Wake with enable off: status only, no wake output
        @(posedge core_clk);
        wake_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, pri_wake_n}, 32'h1);
        rd(OFF_PMCSR, CS | 32'h8000);
        rd(OFF_IRQ_STAT, 32'h2);
        wr(OFF_PMCSR, 32'h100);
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, pri_wake_n}, 32'h0);
        // Subsystem lets go before the status is cleared
        @(posedge core_clk);
        wake_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr(OFF_PMCSR, 32'h8100);
        @(negedge core_clk);
        chk({31'h0, pri_wake_n}, 32'h1);
        // Second request: input passes the synchroniser first
        @(posedge core_clk);
        wake_req <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, pri_wake_n}, 32'h1);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, pri_wake_n}, 32'h0);
        @(posedge core_clk);
        wake_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr(OFF_PMCSR, 32'h0);
        @(negedge core_clk);
        chk({31'h0, pri_wake_n}, 32'h1);
        wr(OFF_PMCSR, 32'h8000);
        // Wake not supported in D1: nothing set
        wr(OFF_PMCSR, 32'h1);
        wake_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(OFF_PMCSR, CS | 32'h1);
        wake_req <= 1'b0;
        // Upward move must aim at D0; D3hot to D0 is a chip reset
        wr(OFF_PMCSR, 32'h3);
        wr(OFF_PMCSR, 32'h1);
        rd(OFF_PMCSR, CS | 32'h3);
        preload_word <= PLW & ~32'h200;
        low_cnt = 0;
        pl_cnt = 0;
        wr(OFF_PMCSR, 32'h0);
        wait_idle();
        chk(32'(low_cnt), SRC);
        chk(32'(pl_cnt), PLC);
        rd(OFF_IRQ_MASK, 32'h3);
        rd(OFF_PMCSR, CS);
        rd(OFF_PMCAP, PLW & 32'h5FF);
        rd(OFF_DATA, 32'h0);
        finish_test();
    end
endmodule // bridge_power_state_and_wake_control_tb
`default_nettype wire
